// ===== tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic clock = 1'b0, rst_n = 1'b0, timer_module_stop_bit = 1'b0, internal_clock_select_ext = 1'b0;
  logic trigger_enable_bit = 1'b0, counter_write = 1'b0, compare_a_irq_enable = 1'b0;
  logic compare_b_irq_enable = 1'b0, overflow_irq_enable = 1'b0, clear_compare_a_flag = 1'b0;
  logic clear_compare_b_flag = 1'b0, clear_overflow_flag = 1'b0;
  logic [2:0] clock_select_field = 3'h0;
  logic [1:0] clear_select = 2'h0, trigger_edge_select = 2'h0, output_select_a = 2'h0, output_select_b = 2'h0;
  logic [7:0] compare_constant_a = 8'hFF, compare_constant_b = 8'hFF, counter_write_data = 8'h00;
  logic [7:0] timer_counter, last_cnt = 8'h00, q_exp, ca, v;
  logic compare_a_flag, compare_b_flag, overflow_flag, compare_a_irq, compare_b_irq, overflow_irq;
  logic timer_output_pin, counting, trigger_in_pin, counter_reset_pin, external_count_clock_pin, out_exp;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h00000040;
  int fail_count = 0;
  int comparisons = 0;
  int n;

  always #50 clock = ~clock;

  tct_timer tct_timer_inst (.clock, .rst_n, .timer_module_stop_bit, .clock_select_field,
    .internal_clock_select_ext, .clear_select, .trigger_enable_bit, .trigger_edge_select, .output_select_a,
    .output_select_b, .compare_a_irq_enable, .compare_b_irq_enable, .overflow_irq_enable, .compare_constant_a,
    .compare_constant_b, .counter_write, .counter_write_data, .clear_compare_a_flag, .clear_compare_b_flag,
    .clear_overflow_flag, .trigger_in_pin, .counter_reset_pin, .external_count_clock_pin, .timer_counter,
    .compare_a_flag, .compare_b_flag, .overflow_flag, .compare_a_irq, .compare_b_irq, .overflow_irq,
    .timer_output_pin, .counting);
  tct_pins_model tct_pins_model_inst (.clock, .trigger_in_pin, .counter_reset_pin, .external_count_clock_pin);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : chk

  task automatic give_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic push_seq(input logic [7:0] first, input int cnt);
    for (int i = 0; i < cnt; i++) begin
      exp_q.push_back(first + 8'(i));
    end
  endtask : push_seq

  task automatic drain(output int cyc);
    cyc = 0;
    while (exp_q.size() != 0 && cyc < 5000) begin
      @(negedge clock);
      cyc++;
    end
    chk("pending results", 8'h00, 8'(exp_q.size()));
  endtask : drain

  task automatic load(input logic [7:0] val);
    if (val !== last_cnt) begin
      exp_q.push_back(val);
    end
    counter_write_data = val;
    counter_write = 1'b1;
    @(negedge clock);
    counter_write = 1'b0;
  endtask : load

  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  // Any counter move that nobody announced is a mismatch, which also
  // catches counting while idle or stopped
  always @(negedge clock) begin
    if (rst_n && timer_counter !== last_cnt) begin
      q_exp = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hXX;
      chk("timer_counter", q_exp, timer_counter);
      last_cnt = timer_counter;
    end
  end

  initial begin
    #6000000;
    fail_count++;
    give_verdict();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    chk("reset state", 8'h00, {timer_counter[2:0], compare_a_flag, compare_b_flag, overflow_flag, timer_output_pin, counting});
    clear_select = 2'h1;
    output_select_a = 2'h3;
    out_exp = 1'b0;
    for (int s = 0; s < 6; s++) begin
      seed = xs(seed);
      ca = 8'h02 + {5'h00, seed[2:0]};
      compare_constant_a = ca;
      compare_a_irq_enable = seed[3];
      repeat (3) begin
        push_seq(8'h01, ca);
        exp_q.push_back(8'h00);
      end
      out_exp = ~out_exp;
      internal_clock_select_ext = s[0];
      clock_select_field = 3'(s / 2 + 1);
      drain(n);
      clock_select_field = 3'h0;
      chk("count rate", 8'h01, 8'(n > (3 * ca + 2) * (4 << s) && n <= (3 * ca + 3) * (4 << s) + 4));
      chk("match a", {6'h00, 1'b1, compare_a_irq_enable}, {6'h00, compare_a_flag, compare_a_irq});
      chk("output toggle", {7'h00, out_exp}, {7'h00, timer_output_pin});
      clear_compare_a_flag = 1'b1;
      @(negedge clock);
      clear_compare_a_flag = 1'b0;
    end
    clear_select = 2'h0;
    overflow_irq_enable = 1'b1;
    load(8'hFD);
    push_seq(8'hFE, 4);
    clock_select_field = 3'h1;
    drain(n);
    clock_select_field = 3'h0;
    chk("overflow", 8'h03, {6'h00, overflow_flag, overflow_irq});
    load(8'h00);
    v = 8'h00;
    for (int c = 5; c < 8; c++) begin
      clock_select_field = 3'(c);
      push_seq(v + 8'h01, (c == 7) ? 6 : 3);
      v = v + ((c == 7) ? 8'h06 : 8'h03);
      tct_pins_model_inst.ext_pulses(3);
      drain(n);
    end
    clock_select_field = 3'h0;
    output_select_a = 2'h0;
    trigger_enable_bit = 1'b1;
    clear_select = 2'h2;
    compare_constant_b = 8'h03;
    internal_clock_select_ext = 1'b0;
    load(8'h00);
    for (int t = 1; t < 4; t++) begin
      trigger_edge_select = 2'(t);
      output_select_b = 2'(t);
      compare_b_irq_enable = t[0];
      clear_compare_b_flag = 1'b1;
      @(negedge clock);
      clear_compare_b_flag = 1'b0;
      clock_select_field = 3'h1;
      repeat (20) @(negedge clock);
      chk("idle before trigger", 8'h00, {7'h00, counting});
      push_seq(8'h01, 3);
      exp_q.push_back(8'h00);
      tct_pins_model_inst.trig_toggle();
      drain(n);
      repeat (30) @(negedge clock);
      chk("stop after clear", 8'h00, {7'h00, counting});
      chk("match b", {6'h00, 1'b1, t[0]}, {6'h00, compare_b_flag, compare_b_irq});
      chk("output b", 8'(t == 2), {7'h00, timer_output_pin});
    end
    trigger_enable_bit = 1'b0;
    clock_select_field = 3'h0;
    clear_select = 2'h3;
    load(8'h40);
    exp_q.push_back(8'h00);
    tct_pins_model_inst.reset_pulse();
    drain(n);
    timer_module_stop_bit = 1'b1;
    clock_select_field = 3'h1;
    repeat (40) @(negedge clock);
    chk("module stopped", 8'h00, {7'h00, counting});
    exp_q.push_back(8'h01);
    timer_module_stop_bit = 1'b0;
    drain(n);
    give_verdict();
  end
endmodule : tb_top

// ===== tct_cfg.svh
`ifndef TCT_CFG_SVH
`define TCT_CFG_SVH

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define TCT_WIDTH 8
`define TCT_PRESCALE_WIDTH 7
`define TCT_COUNT_RESET 8'h00
`define TCT_CONST_RESET 8'hFF
`define TCT_COUNT_MAX 8'hFF

// ----------------------------------------
// Field codes
// ----------------------------------------
`define TCT_CLR_NONE 2'h0
`define TCT_CLR_MATCH_A 2'h1
`define TCT_CLR_MATCH_B 2'h2
`define TCT_CLR_RESET_PIN 2'h3
`define TCT_TRG_NONE 2'h0
`define TCT_TRG_RISE 2'h1
`define TCT_TRG_FALL 2'h2
`define TCT_TRG_BOTH 2'h3
`define TCT_OUT_KEEP 2'h0
`define TCT_OUT_LOW 2'h1
`define TCT_OUT_HIGH 2'h2
`define TCT_OUT_TOGGLE 2'h3
`endif

// ===== tct_pins_model.sv
`timescale 1ns/1ns
module tct_pins_model (
  input wire logic clock,
  output logic trigger_in_pin,
  output logic counter_reset_pin,
  output logic external_count_clock_pin
);
  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Levels move only at falling edges and are held for four cycles,
  // so the two-stage synchronisers always see each level
  initial begin
    trigger_in_pin = 1'b0;
    counter_reset_pin = 1'b0;
    external_count_clock_pin = 1'b0;
  end

  task automatic ext_pulses(input int n);
    repeat (n) begin
      external_count_clock_pin = 1'b1;
      repeat (4) @(negedge clock);
      external_count_clock_pin = 1'b0;
      repeat (4) @(negedge clock);
    end
  endtask : ext_pulses

  // One call gives one edge; its direction follows the present level
  task automatic trig_toggle;
    trigger_in_pin = ~trigger_in_pin;
    @(negedge clock);
  endtask : trig_toggle

  task automatic reset_pulse;
    counter_reset_pin = 1'b1;
    repeat (4) @(negedge clock);
    counter_reset_pin = 1'b0;
  endtask : reset_pulse
endmodule : tct_pins_model

// ===== tct_pkg.sv
package tct_pkg;
  typedef enum logic [1:0] {TCT_IDLE, TCT_RUN} tct_run_type;

  typedef struct packed {
    tct_run_type run;
    logic [7:0] count;
    logic [6:0] prescale;
    logic [1:0] trig_sync;
    logic trig_last;
    logic [1:0] rst_sync;
    logic rst_last;
    logic [1:0] ext_sync;
    logic ext_last;
    logic flag_a;
    logic flag_b;
    logic flag_ovf;
    logic out_pin;
  } tct_state_type;
endpackage : tct_pkg

// ===== tct_timer.sv
`timescale 1ns/1ns
`include "tct_cfg.svh"

module tct_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic timer_module_stop_bit,
  input wire logic [2:0] clock_select_field,
  input wire logic internal_clock_select_ext,
  input wire logic [1:0] clear_select,
  input wire logic trigger_enable_bit,
  input wire logic [1:0] trigger_edge_select,
  input wire logic [1:0] output_select_a,
  input wire logic [1:0] output_select_b,
  input wire logic compare_a_irq_enable,
  input wire logic compare_b_irq_enable,
  input wire logic overflow_irq_enable,
  input wire logic [7:0] compare_constant_a,
  input wire logic [7:0] compare_constant_b,
  input wire logic counter_write,
  input wire logic [7:0] counter_write_data,
  input wire logic clear_compare_a_flag,
  input wire logic clear_compare_b_flag,
  input wire logic clear_overflow_flag,
  input wire logic trigger_in_pin,
  input wire logic counter_reset_pin,
  input wire logic external_count_clock_pin,
  output logic [7:0] timer_counter,
  output logic compare_a_flag,
  output logic compare_b_flag,
  output logic overflow_flag,
  output logic compare_a_irq,
  output logic compare_b_irq,
  output logic overflow_irq,
  output logic timer_output_pin,
  output logic counting
);

  tct_pkg::tct_state_type state_reg;
  tct_pkg::tct_state_type state_next;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic edge_ok(input logic [1:0] sel, input logic prev, input logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = prev & ~cur;
    unique case (sel)
      `TCT_TRG_RISE: edge_ok = rise;
      `TCT_TRG_FALL: edge_ok = fall;
      `TCT_TRG_BOTH: edge_ok = rise | fall;
      default: edge_ok = 1'b0;
    endcase
  endfunction : edge_ok

  function automatic logic out_apply(input logic [1:0] sel, input logic cur);
    unique case (sel)
      `TCT_OUT_LOW: out_apply = 1'b0;
      `TCT_OUT_HIGH: out_apply = 1'b1;
      `TCT_OUT_TOGGLE: out_apply = ~cur;
      default: out_apply = cur;
    endcase
  endfunction : out_apply

  // ----------------------------------------
  // Count tick selection
  // ----------------------------------------
  logic tick;
  logic clk_selected;
  logic [6:0] pre_inc;
  logic ext_edge;

  assign pre_inc = state_reg.prescale + 7'h01;
  // External edge: codes 5 rising, 6 falling, 7 both, so the low two bits are already the edge code
  assign ext_edge = edge_ok(clock_select_field[1:0], state_reg.ext_last, state_reg.ext_sync[1]);

  always_comb begin
    tick = 1'b0;
    clk_selected = 1'b1;
    // Internal ratios: {field,ext} picks /4../128; prescaler rolls so each ratio is a one-cycle enable
    unique case (clock_select_field)
      3'h1: tick = internal_clock_select_ext ? (pre_inc[2:0] == 3'h0) : (pre_inc[1:0] == 2'h0);
      3'h2: tick = internal_clock_select_ext ? (pre_inc[4:0] == 5'h00) : (pre_inc[3:0] == 4'h0);
      3'h3: tick = internal_clock_select_ext ? (pre_inc[6:0] == 7'h00) : (pre_inc[5:0] == 6'h00);
      3'h5, 3'h6, 3'h7: tick = ext_edge;
      default: clk_selected = 1'b0;
    endcase
    if (timer_module_stop_bit) begin
      tick = 1'b0;
      clk_selected = 1'b0;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic match_a;
  logic match_b;
  logic ovf;
  logic rst_rise;
  logic clear_now;
  logic trig_edge;
  logic step;
  logic [7:0] cnt_inc;

  assign cnt_inc = state_reg.count + 8'h01;

  always_comb begin
    state_next = state_reg;
    state_next.trig_sync = {state_reg.trig_sync[0], trigger_in_pin};
    state_next.trig_last = state_reg.trig_sync[1];
    state_next.rst_sync = {state_reg.rst_sync[0], counter_reset_pin};
    state_next.rst_last = state_reg.rst_sync[1];
    state_next.ext_sync = {state_reg.ext_sync[0], external_count_clock_pin};
    state_next.ext_last = state_reg.ext_sync[1];
    state_next.prescale = timer_module_stop_bit ? 7'h00 : pre_inc;

    match_a = (state_reg.count == compare_constant_a);
    match_b = (state_reg.count == compare_constant_b);
    rst_rise = state_reg.rst_sync[1] & ~state_reg.rst_last;
    trig_edge = edge_ok(trigger_edge_select, state_reg.trig_last, state_reg.trig_sync[1]);
    step = (state_reg.run == tct_pkg::TCT_RUN) && tick;
    // Matches are taken once per count tick so a held value does not refire
    ovf = 1'b0;
    clear_now = 1'b0;
    if (step) begin
      ovf = (state_reg.count == `TCT_COUNT_MAX);
      state_next.count = cnt_inc;
      if (match_a) begin
        state_next.flag_a = 1'b1;
        state_next.out_pin = out_apply(output_select_a, state_reg.out_pin);
      end
      if (match_b) begin
        state_next.flag_b = 1'b1;
        state_next.out_pin = out_apply(output_select_b, out_apply(output_select_a & {2{match_a}},
                                                                   state_reg.out_pin));
      end
      if (ovf) begin
        state_next.flag_ovf = 1'b1;
      end
      unique case (clear_select)
        `TCT_CLR_MATCH_A: clear_now = match_a;
        `TCT_CLR_MATCH_B: clear_now = match_b;
        `TCT_CLR_RESET_PIN: clear_now = 1'b0;
        default: clear_now = ovf;
      endcase
    end
    if (clear_select == `TCT_CLR_RESET_PIN && rst_rise) begin
      clear_now = 1'b1;
    end
    if (clear_now) begin
      state_next.count = `TCT_COUNT_RESET;
    end

    // Run control: delay to first match and pulse width both come from the constants
    unique case (state_reg.run)
      tct_pkg::TCT_IDLE: begin
        if (!trigger_enable_bit && clk_selected) begin
          state_next.run = tct_pkg::TCT_RUN;
        end else if (trigger_enable_bit && clk_selected && trig_edge) begin
          state_next.run = tct_pkg::TCT_RUN;
        end
      end
      tct_pkg::TCT_RUN: begin
        if (!clk_selected) begin
          state_next.run = tct_pkg::TCT_IDLE;
        end else if (trigger_enable_bit && clear_now) begin
          state_next.run = tct_pkg::TCT_IDLE;
        end
      end
    endcase

    if (counter_write) begin
      state_next.count = counter_write_data;
    end
    // Hardware set wins over a software clear in the same cycle
    if (clear_compare_a_flag && !(step && match_a)) begin
      state_next.flag_a = 1'b0;
    end
    if (clear_compare_b_flag && !(step && match_b)) begin
      state_next.flag_b = 1'b0;
    end
    if (clear_overflow_flag && !ovf) begin
      state_next.flag_ovf = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.run <= tct_pkg::TCT_IDLE;
      state_reg.count <= `TCT_COUNT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign timer_counter = state_reg.count;
  assign compare_a_flag = state_reg.flag_a;
  assign compare_b_flag = state_reg.flag_b;
  assign overflow_flag = state_reg.flag_ovf;
  assign compare_a_irq = state_reg.flag_a & compare_a_irq_enable;
  assign compare_b_irq = state_reg.flag_b & compare_b_irq_enable;
  assign overflow_irq = state_reg.flag_ovf & overflow_irq_enable;
  assign timer_output_pin = state_reg.out_pin;
  assign counting = (state_reg.run == tct_pkg::TCT_RUN);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_trig_idle;
    trigger_enable_bit && state_reg.run == tct_pkg::TCT_IDLE && !trig_edge;
  endsequence

  sequence s_count_step;
    counting && tick;
  endsequence

  a_stop_no_run: assert property (@(posedge clock) disable iff (!rst_n)
    timer_module_stop_bit |=> !counting)
    else $error("timer ran while module stopped");
  a_free_start: assert property (@(posedge clock) disable iff (!rst_n)
    (!trigger_enable_bit && clk_selected && !counting) |=> counting)
    else $error("free mode did not start");
  a_trig_wait: assert property (@(posedge clock) disable iff (!rst_n)
    s_trig_idle |=> !counting)
    else $error("started without trigger edge");
  a_trig_start: assert property (@(posedge clock) disable iff (!rst_n)
    (trigger_enable_bit && clk_selected && !counting && trig_edge) |=> counting)
    else $error("trigger edge ignored");
  a_trig_stop: assert property (@(posedge clock) disable iff (!rst_n)
    (trigger_enable_bit && counting && clear_now) |=> !counting)
    else $error("did not stop on clear");
  a_clear_zero: assert property (@(posedge clock) disable iff (!rst_n)
    (clear_now && !counter_write) |=> timer_counter == 8'h00)
    else $error("counter not cleared");
  a_count_step: assert property (@(posedge clock) disable iff (!rst_n)
    (counting && tick && !clear_now && !counter_write) |=> timer_counter == $past(timer_counter) + 8'h01)
    else $error("counter did not step");
  a_flag_a_set: assert property (@(posedge clock) disable iff (!rst_n)
    (counting && tick && match_a) |=> compare_a_flag)
    else $error("compare flag a missing");
  a_ovf_set: assert property (@(posedge clock) disable iff (!rst_n)
    (counting && tick && ovf) |=> overflow_flag ##0 (overflow_irq == overflow_irq_enable))
    else $error("overflow flag or request wrong");
  a_write_load: assert property (@(posedge clock) disable iff (!rst_n)
    counter_write |=> timer_counter == $past(counter_write_data))
    else $error("counter write lost");
  a_irq_gate: assert property (@(posedge clock) disable iff (!rst_n)
    compare_b_irq |-> compare_b_flag && compare_b_irq_enable)
    else $error("request b not gated");

  // Checks below, apart from a_idle_hold, look at the decoded fields directly, not at clear_now, so a decode slip shows up
  a_flag_b_set: assert property (@(posedge clock) disable iff (!rst_n)
    (s_count_step ##0 match_b) |=> compare_b_flag)
    else $error("compare flag b missing");
  a_flag_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (clear_compare_a_flag && !(step && match_a)) |=> !compare_a_flag)
    else $error("compare flag a not cleared");
  a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n)
    (compare_b_flag && !clear_compare_b_flag) |=> compare_b_flag)
    else $error("compare flag b dropped");
  a_match_a_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (s_count_step ##0 (clear_select == `TCT_CLR_MATCH_A && timer_counter == compare_constant_a && !counter_write))
    |=> timer_counter == `TCT_COUNT_RESET)
    else $error("match a did not clear counter");
  a_match_b_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (s_count_step ##0 (clear_select == `TCT_CLR_MATCH_B && timer_counter == compare_constant_b && !counter_write))
    |=> timer_counter == `TCT_COUNT_RESET)
    else $error("match b did not clear counter");
  a_pin_clear: assert property (@(posedge clock) disable iff (!rst_n)
    (clear_select == `TCT_CLR_RESET_PIN && rst_rise && !counter_write) |=> timer_counter == `TCT_COUNT_RESET)
    else $error("reset pin did not clear counter");
  a_idle_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (!counting && !clear_now && !counter_write) |=> timer_counter == $past(timer_counter))
    else $error("counter moved while idle");
  a_prescale_stop: assert property (@(posedge clock) disable iff (!rst_n)
    timer_module_stop_bit |=> state_reg.prescale == 7'h00)
    else $error("prescaler ran while module stopped");
  a_out_toggle_a: assert property (@(posedge clock) disable iff (!rst_n)
    (s_count_step ##0 (match_a && !match_b && output_select_a == `TCT_OUT_TOGGLE))
    |=> timer_output_pin != $past(timer_output_pin))
    else $error("output did not toggle on match a");
  a_out_low_b: assert property (@(posedge clock) disable iff (!rst_n)
    (s_count_step ##0 (match_b && output_select_b == `TCT_OUT_LOW)) |=> !timer_output_pin)
    else $error("output not low on match b");
  a_out_high_b: assert property (@(posedge clock) disable iff (!rst_n)
    (s_count_step ##0 (match_b && output_select_b == `TCT_OUT_HIGH)) |=> timer_output_pin)
    else $error("output not high on match b");
  a_out_keep: assert property (@(posedge clock) disable iff (!rst_n)
    !(counting && tick && (match_a || match_b)) |=> timer_output_pin == $past(timer_output_pin))
    else $error("output moved without a match");
  a_irq_a_raise: assert property (@(posedge clock) disable iff (!rst_n)
    (compare_a_flag && compare_a_irq_enable) |-> compare_a_irq)
    else $error("request a missing");
  a_irq_ovf_raise: assert property (@(posedge clock) disable iff (!rst_n)
    (overflow_flag && overflow_irq_enable) |-> overflow_irq)
    else $error("overflow request missing");

endmodule : tct_timer
